// File: design/orpvs_pkg.sv
// Constants, timing counts and state types of the OTP program/verify sequencer.
// Assumes a single 125 MHz system clock.
package orpvs_pkg;

   // Clock rate
   localparam int CLK_MHZ = 125;

   // Pin-level times, as printed
   localparam int PROGRAM_PULSE_WIDTH_US     = 50;
   localparam int PULSE_MIN_NS               = 47500;
   localparam int PULSE_MAX_NS               = 52500;
   localparam int ALE_WIDTH_NS               = 500;
   localparam int LATCHED_ADDR_SETUP_NS      = 100;
   localparam int LATCHED_ADDR_HOLD_NS       = 100;
   localparam int PROGRAM_SUPPLY_RECOVERY_US = 2;
   localparam int SUPPLY_STEP_US             = 2;
   localparam int DATA_VALID_NS              = 150;
   localparam int OUTPUT_FLOAT_NS            = 130;

   // Cycle counts: least times round up, longest round down
   localparam int PULSE_CYC     = PROGRAM_PULSE_WIDTH_US * CLK_MHZ;
   localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int PULSE_MAX_CYC = (PULSE_MAX_NS * CLK_MHZ) / 1000;
   localparam int ALE_CYC       = (ALE_WIDTH_NS * CLK_MHZ + 999) / 1000;
   localparam int LAS_CYC       = (LATCHED_ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int LAH_CYC       = (LATCHED_ADDR_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int VR_CYC        = PROGRAM_SUPPLY_RECOVERY_US * CLK_MHZ;
   localparam int STEP_CYC      = SUPPLY_STEP_US * CLK_MHZ;
   localparam int TOE_CYC       = (DATA_VALID_NS * CLK_MHZ + 999) / 1000;
   localparam int DFP_CYC       = (OUTPUT_FLOAT_NS * CLK_MHZ + 999) / 1000;
   localparam int SYNC_LAT      = 2;

   // Sizes and limits
   localparam int MAX_RETRY = 10;
   localparam int TMR_W     = 13;
   localparam int ADDR_W    = 16;
   localparam int DATA_W    = 8;

   // Programming passes
   typedef enum logic [1:0] {PH_BLANK, PH_VERIFY, PH_FINAL} orpvs_phase_t;

   // Sequencer states
   typedef enum logic [4:0] {
      S_IDLE, S_PWRUP, S_FETCH, S_LSET, S_LHI, S_LHOLD, S_DSET, S_HVUP,
      S_PULSE, S_DHOLD, S_RECOV, S_READ, S_CHECK, S_SUPDN, S_IDPWR,
      S_IDRD, S_IDSW, S_PWROFF, S_VOFF
   } orpvs_state_t;

endpackage

// File: design/orpvs_sequencer.sv
// Programmer-side sequencer for a 64K x 8 OTP memory with multiplexed lines.
// Assumes supply switches follow vcc_on/vcc_prog/vpp_hv/id_hv levels.
// Functional notes
// - Program each byte with a 50 us latch-strobe pulse.
// - Keep every program pulse between 47.5 and 52.5 us.
// - Start at address zero; raise core 6.5 V, then 13 V before pulsing.
// - First pass gives each address exactly one pulse, no verify read.
// - Verify loop per address; on mismatch pulse again and re-read, up to 10.
// - Still mismatching after ten retries: stop and report failure.
// - After a good verify, advance until every address is checked.
// - Then drop to logic level and 5 V, re-read all and compare.
// - Core supply on no later, and off no earlier, than program supply.
// - Latch strobe high 500 ns; address stable 100 ns around the latch edge.
// - Wait 2 us after high voltage removal before any read.
// - Identification read holds upper address low except bit 0, which selects the byte; mode bit at high voltage.
`timescale 1ns/1ps
`default_nettype none

module orpvs_sequencer
   import orpvs_pkg::*;
#(
   parameter int PULSE_CYCLES = PULSE_CYC,
   parameter int AW           = ADDR_W
)
(
   // Clock and reset
   input wire logic              sys_clk_i,
   input wire logic              nrst_i,
   // Commands
   input wire logic              start_i,
   input wire logic              id_req_i,
   // Source image
   output logic     [AW-1:0]     src_addr_o,
   output logic                  src_req_o,
   input wire logic [DATA_W-1:0] src_data_i,
   input wire logic              src_valid_i,
   // Status
   output logic                  busy_o,
   output logic                  done_o,
   output logic                  pass_o,
   output logic                  fail_o,
   output logic     [AW-1:0]     fail_addr_o,
   output logic     [DATA_W-1:0] maker_id_o,
   output logic     [DATA_W-1:0] type_id_o,
   // Memory pins
   input wire logic [DATA_W-1:0] muxed_addr_data_lines_i,
   output logic     [DATA_W-1:0] muxed_addr_data_lines_o,
   output logic                  muxed_addr_data_lines_oe_o,
   output logic     [AW-9:0]     upper_addr_o,
   output logic                  ale_o,
   output logic                  oe_n_o,
   output logic                  vpp_hv_o,
   output logic                  id_hv_o,
   output logic                  vcc_on_o,
   output logic                  vcc_prog_o
);

   orpvs_state_t          state_q, state_d;
   orpvs_phase_t          phase_q, phase_d;
   logic [AW-1:0]         addr_q, addr_d;
   logic [3:0]            retry_q, retry_d;
   logic [DATA_W-1:0]     src_q, src_d;
   logic                  prog_q, prog_d;
   logic                  pass_q, pass_d, fail_q, fail_d, done_q, done_d;
   logic [AW-1:0]         faddr_q, faddr_d;
   logic [DATA_W-1:0]     maker_q, maker_d, type_q, type_d;
   logic                  id_byte_select_bit_q, id_byte_select_bit_d;
   logic [DATA_W-1:0]     rd_data;
   logic                  adv, match, last, exp_w;
   int                    cyc;

   // Registered pins
   logic                  ale_q, oe_n_q, hv_q, idhv_q, von_q, vprog_q, adoe_q;
   logic [DATA_W-1:0]     adout_q;
   logic [AW-9:0]         upper_q;
   logic                  ale_d, oe_n_d, hv_d, idhv_d, von_d, vprog_d, adoe_d;
   logic [DATA_W-1:0]     adout_d;
   logic [AW-9:0]         upper_d;

   orpvs_tmr_if #(.W(TMR_W)) tmr_bus ();

   orpvs_timer #(.W(TMR_W)) u_timer (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .tmr       (tmr_bus)
   );

   // Pin inputs come from outside the clock domain
   orpvs_sync #(.W(DATA_W)) u_sync (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .d_i       (muxed_addr_data_lines_i),
      .q_o       (rd_data)
   );

   // Compare and address decode
   assign exp_w = tmr_bus.expired;
   assign match = (rd_data == src_q);
   assign last  = (addr_q == {AW{1'b1}});

   // Sequencing
   always_comb
   begin
      state_d = state_q;
      phase_d = phase_q;
      addr_d  = addr_q;
      retry_d = retry_q;
      src_d   = src_q;
      prog_d  = prog_q;
      pass_d  = pass_q;
      fail_d  = fail_q;
      faddr_d = faddr_q;
      done_d  = 1'b0;
      maker_d = maker_q;
      type_d  = type_q;
      id_byte_select_bit_d = id_byte_select_bit_q;
      adv     = 1'b0;
      unique case (state_q)
         S_IDLE:
            if (start_i)
            begin
               state_d = S_PWRUP;
               phase_d = PH_BLANK;
               addr_d  = '0;
               retry_d = '0;
               prog_d  = 1'b1;
               pass_d  = 1'b0;
               fail_d  = 1'b0;
            end
            else if (id_req_i)
            begin
               state_d = S_IDPWR;
               id_byte_select_bit_d = 1'b0;
            end
         S_PWRUP:  if (exp_w) state_d = S_FETCH;
         // Also lets the memory float its outputs after a read
         S_FETCH:
            if (exp_w && src_valid_i)
            begin
               src_d   = src_data_i;
               state_d = S_LSET;
            end
         S_LSET:   if (exp_w) state_d = S_LHI;
         S_LHI:    if (exp_w) state_d = S_LHOLD;
         S_LHOLD:  if (exp_w) state_d = prog_q ? S_DSET : S_READ;
         S_DSET:   if (exp_w) state_d = S_HVUP;
         S_HVUP:   if (exp_w) state_d = S_PULSE;
         S_PULSE:  if (exp_w) state_d = S_DHOLD;
         S_DHOLD:  if (exp_w) state_d = S_RECOV;
         S_RECOV:
            if (exp_w)
            begin
               if (phase_q == PH_BLANK)
                  adv = 1'b1;
               else
               begin
                  prog_d  = 1'b0;
                  state_d = S_LSET;
               end
            end
         S_READ:   if (exp_w) state_d = S_CHECK;
         S_CHECK:
            if (match)
               adv = 1'b1;
            else if (phase_q == PH_VERIFY && retry_q < 4'(MAX_RETRY))
            begin
               retry_d = retry_q + 1'b1;
               prog_d  = 1'b1;
               state_d = S_FETCH;
            end
            else
            begin
               fail_d  = 1'b1;
               faddr_d = addr_q;
               state_d = S_PWROFF;
            end
         S_SUPDN:  if (exp_w) state_d = S_FETCH;
         S_IDPWR:  if (exp_w) state_d = S_IDRD;
         S_IDRD:
            if (exp_w)
            begin
               if (!id_byte_select_bit_q)
               begin
                  maker_d = rd_data;
                  state_d = S_IDSW;
               end
               else
               begin
                  type_d  = rd_data;
                  state_d = S_PWROFF;
               end
            end
         S_IDSW:
         begin
            id_byte_select_bit_d = 1'b1;
            state_d = S_IDRD;
         end
         S_PWROFF: if (exp_w) state_d = S_VOFF;
         S_VOFF:
            if (exp_w)
            begin
               done_d  = 1'b1;
               state_d = S_IDLE;
            end
         default:  state_d = S_IDLE;
      endcase
      // Next address, or next pass or power-off after the last one
      if (adv)
      begin
         retry_d = '0;
         state_d = S_FETCH;
         if (!last)
            addr_d = addr_q + 1'b1;
         else
         begin
            addr_d = '0;
            prog_d = 1'b0;
            unique case (phase_q)
               PH_BLANK:  phase_d = PH_VERIFY;
               PH_VERIFY:
               begin
                  phase_d = PH_FINAL;
                  state_d = S_SUPDN;
               end
               default:
               begin
                  pass_d  = 1'b1;
                  state_d = S_PWROFF;
               end
            endcase
         end
      end
   end

   // Wait length of the state being entered
   always_comb
   begin
      unique case (state_d)
         S_PWRUP, S_DSET, S_HVUP, S_DHOLD, S_IDPWR, S_VOFF: cyc = STEP_CYC;
         S_FETCH:                 cyc = DFP_CYC;
         S_LSET:                  cyc = LAS_CYC;
         S_LHI:                   cyc = ALE_CYC;
         S_LHOLD:                 cyc = LAH_CYC;
         S_PULSE:                 cyc = PULSE_CYCLES;
         S_RECOV, S_SUPDN, S_PWROFF: cyc = VR_CYC;
         S_READ, S_IDRD:          cyc = TOE_CYC + SYNC_LAT;
         default:                 cyc = 1;
      endcase
   end

   assign tmr_bus.load = (state_d != state_q);
   assign tmr_bus.val  = TMR_W'(cyc - 1);

   // Pin levels decoded from the next state, so pins change with the state
   assign ale_d   = (state_d == S_LHI) || (state_d == S_PULSE);
   assign hv_d    = state_d inside {S_HVUP, S_PULSE, S_DHOLD};
   assign oe_n_d  = !(state_d inside {S_READ, S_CHECK, S_IDRD, S_IDSW});
   assign idhv_d  = state_d inside {S_IDPWR, S_IDRD, S_IDSW};
   assign von_d   = !(state_d inside {S_IDLE, S_VOFF});
   assign vprog_d = !(state_d inside {S_IDLE, S_VOFF, S_PWROFF, S_SUPDN, S_IDPWR, S_IDRD, S_IDSW})
                    && (phase_d != PH_FINAL);
   assign adoe_d  = state_d inside {S_LSET, S_LHI, S_LHOLD, S_DSET, S_HVUP, S_PULSE, S_DHOLD, S_RECOV};
   assign adout_d = (state_d inside {S_LSET, S_LHI, S_LHOLD}) ? addr_d[7:0] : src_d;
   assign upper_d = idhv_d ? {{(AW-9){1'b0}}, id_byte_select_bit_d} : addr_d[AW-1:8];

   // State and data registers
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_q <= S_IDLE;
         phase_q <= PH_BLANK;
         addr_q  <= '0;
         retry_q <= '0;
         src_q   <= '0;
         prog_q  <= 1'b0;
         pass_q  <= 1'b0;
         fail_q  <= 1'b0;
         done_q  <= 1'b0;
         faddr_q <= '0;
         maker_q <= '0;
         type_q  <= '0;
         id_byte_select_bit_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         phase_q <= phase_d;
         addr_q  <= addr_d;
         retry_q <= retry_d;
         src_q   <= src_d;
         prog_q  <= prog_d;
         pass_q  <= pass_d;
         fail_q  <= fail_d;
         done_q  <= done_d;
         faddr_q <= faddr_d;
         maker_q <= maker_d;
         type_q  <= type_d;
         id_byte_select_bit_q <= id_byte_select_bit_d;
      end
   end

   // Pin registers; all supplies off and lines released in reset
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         {ale_q, hv_q, idhv_q, von_q, vprog_q, adoe_q} <= '0;
         oe_n_q  <= 1'b1;
         adout_q <= '0;
         upper_q <= '0;
      end
      else
      begin
         {ale_q, hv_q, idhv_q, von_q, vprog_q, adoe_q} <= {ale_d, hv_d, idhv_d, von_d, vprog_d, adoe_d};
         oe_n_q  <= oe_n_d;
         adout_q <= adout_d;
         upper_q <= upper_d;
      end
   end

   assign src_addr_o   = addr_q;
   assign src_req_o    = (state_q == S_FETCH);
   assign busy_o       = (state_q != S_IDLE);
   assign done_o       = done_q;
   assign pass_o       = pass_q;
   assign fail_o       = fail_q;
   assign fail_addr_o  = faddr_q;
   assign maker_id_o   = maker_q;
   assign type_id_o    = type_q;
   assign muxed_addr_data_lines_o    = adout_q;
   assign muxed_addr_data_lines_oe_o = adoe_q;
   assign upper_addr_o = upper_q;
   assign ale_o        = ale_q;
   assign oe_n_o       = oe_n_q;
   assign vpp_hv_o     = hv_q;
   assign id_hv_o      = idhv_q;
   assign vcc_on_o     = von_q;
   assign vcc_prog_o   = vprog_q;

   // Checker helpers: strobe high length, cycles since high voltage left
   logic [TMR_W-1:0] ale_cnt_q;
   logic [7:0]       hv_off_q;
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ale_cnt_q <= '0;
         hv_off_q  <= 8'hFF;
      end
      else
      begin
         ale_cnt_q <= ale_o ? ale_cnt_q + 1'b1 : '0;
         hv_off_q  <= vpp_hv_o ? 8'h00 : ((hv_off_q == 8'hFF) ? hv_off_q : hv_off_q + 1'b1);
      end
   end

   pulse_width_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      $fell(ale_o) && vpp_hv_o |-> ale_cnt_q == TMR_W'(PULSE_CYCLES))
      else $error("program pulse length wrong");
   pulse_window_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      $fell(ale_o) && vpp_hv_o && PULSE_CYCLES >= PULSE_MIN_CYC
      |-> ale_cnt_q >= TMR_W'(PULSE_MIN_CYC) && ale_cnt_q <= TMR_W'(PULSE_MAX_CYC))
      else $error("program pulse outside tolerance");
   hv_on_prog_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      $rose(vpp_hv_o) |-> vcc_prog_o && $past(vcc_prog_o, 2))
      else $error("high voltage before core programming supply");
   blank_once_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      state_q == S_RECOV && exp_w && phase_q == PH_BLANK |=> state_q == S_FETCH)
      else $error("blank pass did not move on after one pulse");
   retry_cap_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      state_q == S_CHECK && !match && phase_q == PH_VERIFY && retry_q < 4'(MAX_RETRY)
      |=> retry_q == $past(retry_q) + 1'b1 && prog_q)
      else $error("retry not counted");
   fail_limit_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      state_q == S_CHECK && !match && retry_q == 4'(MAX_RETRY) |=> fail_o && state_q == S_PWROFF)
      else $error("failure not reported at retry limit");
   advance_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      state_q == S_CHECK && match && !last |=> src_addr_o == AW'($past(src_addr_o) + 1'b1))
      else $error("address did not advance");
   final_levels_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      !oe_n_o && phase_q == PH_FINAL |-> !vpp_hv_o && !vcc_prog_o)
      else $error("final read at programming levels");
   supply_order_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      vpp_hv_o |-> vcc_on_o && $past(vcc_on_o))
      else $error("program supply without core supply");
   latch_width_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      $fell(ale_o) && !vpp_hv_o |-> ale_cnt_q >= TMR_W'(ALE_CYC))
      else $error("latch strobe too short");
   latch_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      state_q == S_LHOLD |-> $stable(muxed_addr_data_lines_o) && muxed_addr_data_lines_oe_o)
      else $error("address moved during latch hold");
   recovery_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      $fell(oe_n_o) |-> hv_off_q >= 8'(VR_CYC))
      else $error("read too soon after high voltage");
   id_entry_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      id_hv_o |-> upper_addr_o[AW-9:1] == '0 && !vpp_hv_o)
      else $error("identification entry with upper address high");
   verify_en_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      state_q == S_CHECK && phase_q != PH_FINAL |-> !oe_n_o && vcc_prog_o && !muxed_addr_data_lines_oe_o)
      else $error("verify without outputs enabled at program supply");

endmodule

`default_nettype wire

// File: design/orpvs_sync.sv
// Two-flop synchroniser for the bus read back from the memory pins.
// Bits are not coherent; callers sample only after the lines settle.
`timescale 1ns/1ps
`default_nettype none

module orpvs_sync #(parameter int W = 8)
(
   // Clock and reset
   input wire logic          sys_clk_i,
   input wire logic          nrst_i,
   // Data
   input wire logic [W-1:0]  d_i,
   output logic     [W-1:0]  q_o
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // First stage feeds only the second
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;

endmodule

`default_nettype wire

// File: design/orpvs_timer.sv
// Down-counting wait timer; a load of N-1 expires after N cycles.
// Expects load as a one-cycle pulse on state entry.
`timescale 1ns/1ps
`default_nettype none

module orpvs_timer #(parameter int W = 13)
(
   // Clock and reset
   input wire logic    sys_clk_i,
   input wire logic    nrst_i,
   // Control from the sequencer
   orpvs_tmr_if.tmr    tmr
);

   logic [W-1:0] cnt_q;

   // Count down, hold at zero
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         cnt_q <= '0;
      else if (tmr.load)
         cnt_q <= tmr.val;
      else if (cnt_q != '0)
         cnt_q <= cnt_q - 1'b1;
   end

   // No load term here: load itself depends on expiry
   assign tmr.expired = (cnt_q == '0);

endmodule

`default_nettype wire

// File: design/orpvs_tmr_if.sv
// Load/expiry handshake between the sequencer and its wait timer.
// Both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none

interface orpvs_tmr_if #(parameter int W = 13);
   logic         load;
   logic [W-1:0] val;
   logic         expired;
   modport ctl (output load, val, input expired);
   modport tmr (input load, val, output expired);
endinterface

`default_nettype wire

// File: verif/orpvs_mem_model.sv
// Behavioural OTP memory on the sequencer pins; one weak cell, one cell that can stick.
// Assumes the bench resolves the shared lines and reads err_o.
`timescale 1ns/1ps
`default_nettype none

module orpvs_mem_model
#(
   parameter int         AW    = 10,
   parameter real        PW_NS = 160.0,
   parameter logic [7:0] MAKER = 8'h3C, // Arbitrary value
   parameter logic [7:0] DTYPE = 8'hC3  // Arbitrary value
)
(
   // Pins from the sequencer
   input wire logic [7:0]    ad_i,
   input wire logic [AW-9:0] up_i,
   input wire logic          ale_i,
   input wire logic          oe_n_i,
   input wire logic          vpp_i,
   input wire logic          idhv_i,
   input wire logic          vcc_i,
   input wire logic          vprog_i,
   // Replies and fault count
   output logic [7:0]        ad_o,
   output logic              ad_oe_o,
   output var int            err_o
);
   localparam int WEAK  = 5; // Takes three pulses
   localparam int STUCK = 2; // Bit 0 never clears while stuck is set
   logic [7:0]         mem [2**AW];
   int                 pulses [2**AW];
   int                 vfy_rd = 0;
   int                 fin_rd = 0;
   logic               stuck = 1'b0;
   logic [7:0]         lo_q = 8'h00;
   realtime            t_ale, t_ad;
   realtime            t_fall = -1.0e3;
   realtime            t_vpp = -1.0e4;
   wire logic [AW-1:0] a = {up_i, lo_q};

   // Erased cells read all ones
   initial
   begin
      err_o = 0;
      foreach (mem[i])
      begin
         mem[i] = 8'hFF;
         pulses[i] = 0;
      end
   end

   // Strobe under high voltage programs; otherwise it latches the low address
   always @(posedge ale_i) t_ale = $realtime;
   always @(negedge ale_i)
   begin
      if (vpp_i)
      begin
         if ($realtime - t_ale < 0.95 * PW_NS || $realtime - t_ale > 1.05 * PW_NS) err_o++;
         pulses[a]++;
         if (a != WEAK || pulses[a] > 2) mem[a] &= ad_i;
      end
      else if (vcc_i) // Unknown-to-low at power-up is no latch
      begin
         if ($realtime - t_ale < 500.0 || $realtime - t_ad < 100.0) err_o++;
         lo_q = ad_i;
         t_fall = $realtime;
      end
   end

   // Hold after latching, supply order, recovery before reads
   always @(ad_i) if (!ale_i && $realtime - t_fall < 100.0) err_o++;
   always @(ad_i) t_ad = $realtime;
   always @(posedge vpp_i) if (!vcc_i || !vprog_i) err_o++;
   always @(negedge vcc_i) if (vpp_i) err_o++;
   always @(negedge vpp_i) t_vpp = $realtime;
   always @(negedge oe_n_i)
   begin
      if ($realtime - t_vpp < 2000.0) err_o++;
      if (vprog_i) vfy_rd++;
      else fin_rd++;
   end

   // Drive only when enabled out of high voltage; ID bytes replace the array
   assign ad_oe_o = !oe_n_i && !vpp_i && vcc_i;
   assign ad_o    = idhv_i ? (up_i[0] ? DTYPE : MAKER) : mem[a] | {7'h00, stuck && a == STUCK};

endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Bench: identification, good and failing program runs, refused start, reset.
// Assumes a 10-bit address and short pulse; a full run still takes about 1.4M cycles.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam int         AW  = 10;
   localparam int         PC  = 20;
   localparam int         LIM = 3500000;
   localparam logic [7:0] MK  = 8'h3C; // Arbitrary value
   localparam logic [7:0] DT  = 8'hC3; // Arbitrary value
   typedef struct {logic st; logic id; logic stk; logic ps; logic fl; int a; int pl; int vr; int fr;} orpvs_row_t;

   // Command, stuck cell, flags, watched address, pulses there, verify and final reads
   orpvs_row_t rows [3] = '{
      '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 0, 0, 0, 1},
      '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 5, 3, 1026, 1024},
      '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2, 12, 13, 0}};
   logic          sys_clk_i   = 1'b0;
   logic          nrst_i      = 1'b0;
   logic          start_i     = 1'b0;
   logic          id_req_i    = 1'b0;
   logic          src_valid_i = 1'b0;
   logic [7:0]    src_data_i  = 8'h00;
   logic [7:0]    h_o, d_o, w, maker, dtype;
   logic          h_oe, d_oe, src_req, busy, done, pass, fail, ale, oe_n, vpp, idhv, vcc, vprog;
   logic [AW-1:0] src_addr, fail_addr;
   logic [AW-9:0] up;
   int            bad_count = 0;
   int            cmp_count = 0;
   int            cyc = 0;
   int            err_m, v0, f0;

   initial
   begin
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   // Released lines flip every cycle, so a stale value never passes
   assign w = h_oe ? h_o : (d_oe ? d_o : 8'h5A ^ {8{cyc[0]}});

   // Source image answers each request half a cycle later
   always @(negedge sys_clk_i)
   begin
      src_data_i  <= src_addr[7:0] ^ 8'h5A;
      src_valid_i <= src_req;
   end

   // Hang guard
   always @(posedge sys_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == LIM)
      begin
         bad_count++;
         summarize();
      end
   end

   orpvs_sequencer #(.PULSE_CYCLES(PC), .AW(AW)) dut_u
   (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .start_i(start_i), .id_req_i(id_req_i),
      .src_addr_o(src_addr), .src_req_o(src_req), .src_data_i(src_data_i), .src_valid_i(src_valid_i),
      .busy_o(busy), .done_o(done), .pass_o(pass), .fail_o(fail), .fail_addr_o(fail_addr),
      .maker_id_o(maker), .type_id_o(dtype), .muxed_addr_data_lines_i(w), .muxed_addr_data_lines_o(h_o),
      .muxed_addr_data_lines_oe_o(h_oe), .upper_addr_o(up), .ale_o(ale), .oe_n_o(oe_n),
      .vpp_hv_o(vpp), .id_hv_o(idhv), .vcc_on_o(vcc), .vcc_prog_o(vprog)
   );

   orpvs_mem_model #(.AW(AW), .PW_NS(PC * 8.0), .MAKER(MK), .DTYPE(DT)) mdl_u
   (
      .ad_i(w), .up_i(up), .ale_i(ale), .oe_n_i(oe_n), .vpp_i(vpp), .idhv_i(idhv),
      .vcc_i(vcc), .vprog_i(vprog), .ad_o(d_o), .ad_oe_o(d_oe), .err_o(err_m)
   );

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // One command, an optional start poke in mid-run, bounded wait for done
   task automatic go(input logic st, input logic id, input int poke);
      int n;
      n = 0;
      @(negedge sys_clk_i);
      start_i  = st;
      id_req_i = id;
      @(negedge sys_clk_i);
      start_i  = 1'b0;
      id_req_i = 1'b0;
      while (done !== 1'b1 && n < 2000000)
      begin
         @(negedge sys_clk_i);
         n++;
         start_i = (n == poke);
      end
      check("done", done, 1'b1);
   endtask

   initial
   begin
      repeat (3) @(negedge sys_clk_i);
      nrst_i = 1'b1;
      check("idle pins", {vcc, vprog, vpp, idhv, ale, oe_n, h_oe, busy}, 8'h04);
      foreach (rows[i])
      begin
         mdl_u.stuck = rows[i].stk;
         v0 = mdl_u.vfy_rd;
         f0 = mdl_u.fin_rd;
         go(rows[i].st, rows[i].id, 0);
         check("pass", pass, rows[i].ps);
         check("fail", fail, rows[i].fl);
         check("pulses", mdl_u.pulses[rows[i].a], rows[i].pl);
         check("verify reads", mdl_u.vfy_rd - v0, rows[i].vr);
         check("final reads", mdl_u.fin_rd - f0, rows[i].fr);
         if (rows[i].id) check("ids", {maker, dtype}, {MK, DT});
         if (rows[i].fl) check("fail address", fail_addr, rows[i].a);
         $display("row %0d finished", i);
      end
      // A start during an identification run is ignored and keeps the flags
      go(1'b0, 1'b1, 100);
      repeat (2) @(negedge sys_clk_i);
      check("busy after refused start", busy, 1'b0);
      check("fail kept", fail, 1'b1);
      $display("refusal test finished");
      // Reset in recovery, after high voltage is off
      start_i = 1'b1;
      @(negedge sys_clk_i);
      start_i = 1'b0;
      repeat (1200) @(negedge sys_clk_i);
      nrst_i = 1'b0;
      @(negedge sys_clk_i);
      check("pins in reset", {vcc, vprog, vpp, idhv, ale, oe_n, h_oe, busy, fail}, 9'h008);
      nrst_i = 1'b1;
      @(negedge sys_clk_i);
      check("idle after reset", {busy, vcc, vpp, ale, h_oe, done}, 6'h00);
      $display("reset test finished");
      check("model faults", err_m, 0);
      summarize();
   end

endmodule
`default_nettype wire
